// file: hdl/tac_top.v
// Terminator, auto-filter and remote state command handling
// Operation
// - Strings end in selected CR/LF terminator
// - Clears reload saved terminator, power-up loads factory CR/LF
// - EOI asserted with final terminator byte
// - Clears reload saved auto-filter, power-up loads factory on
// - Auto rise only top three gains, filter off
// - Rise 10/30/100 us for 1e8/1e9/1e10
// - Main filter on uses programmed rise time
// - Lower gains get no filtering in auto
// - Remote needs REN then listen addressing
// - Talking allowed in local or remote
// - Remote ignores keys except local
// - Local key exits remote unless locked out
// - Remote lamp lit while remote
// - Default primary bus address is 22
// - Commands buffered to 128, run on execute
`timescale 1ns/1ps
`default_nettype none
`include "tac_consts.vh"

module tac_top (
    input  wire                   CLK_SYS,
    input  wire                   RST_N,
    input  wire [7:0]             RX_BYTE,
    input  wire                   RX_VALID,
    input  wire                   DEV_CLEAR,
    input  wire                   SEL_DEV_CLEAR,
    input  wire                   SAVE_DEFAULTS_CMD,
    input  wire                   EOI_ENABLE,
    input  wire                   REN,
    input  wire                   LISTEN_ADDRESSED,
    input  wire                   TALK_ADDRESSED,
    input  wire                   LOCAL_LOCKOUT,
    input  wire                   GO_TO_LOCAL,
    input  wire                   LOCAL_KEY,
    input  wire                   PANEL_KEY_VALID,
    input  wire [7:0]             PANEL_KEY_CODE,
    input  wire                   STRING_DONE,
    input  wire                   TX_ACK,
    input  wire                   MAIN_FILTER_ON,
    input  wire [2:0]             PROG_RISE,
    input  wire [3:0]             GAIN_EXP,
    output wire [7:0]             TX_BYTE,
    output wire                   TX_VALID,
    output wire                   TX_EOI,
    output wire                   TERM_BUSY,
    output reg  [1:0]             TERM_SEL,
    output reg                    AUTO_FILTER_ON,
    output reg  [2:0]             RISE_SEL,
    output reg                    FILTER_ACTIVE,
    output reg                    REMOTE,
    output reg                    HOST_CONTROL_LAMP,
    output reg                    PANEL_KEY_OUT_VALID,
    output reg  [7:0]             PANEL_KEY_OUT_CODE,
    output reg                    CMD_INVALID,
    output reg                    BUF_OVERFLOW,
    output reg  [4:0]             PRIMARY_ADDR
);

    // Execute states
    localparam ST_IDLE = 2'h0;
    localparam ST_SCAN = 2'h1;
    localparam ST_DONE = 2'h2;

    reg [7:0]              cmd_buf [0:`TAC_BUF_DEPTH-1];
    reg [`TAC_BUF_AW:0]    wr_cnt;
    reg [`TAC_BUF_AW:0]    rd_idx;
    reg [1:0]              state;
    reg [1:0]              saved_term;
    reg                    saved_auto;
    reg [1:0]              pend_term;
    reg                    pend_auto;
    reg                    have_term;
    reg                    have_auto;
    reg                    bad;
    reg [7:0]              pend_letter;
    reg                    ren_seen;

    wire clear_req = DEV_CLEAR | SEL_DEV_CLEAR | SAVE_DEFAULTS_CMD;
    wire rx_exec   = RX_VALID && (RX_BYTE == `TAC_CHAR_EXEC);
    wire [7:0] scan_byte = cmd_buf[rd_idx[`TAC_BUF_AW-1:0]];

    // Terminator sent after each string whether local or remote
    tac_term_seq u_term (
        .clk       (CLK_SYS),
        .rst_n     (RST_N),
        .term_sel  (TERM_SEL),
        .eoi_en    (EOI_ENABLE),
        .start     (STRING_DONE & TALK_ADDRESSED & ~TERM_BUSY),
        .byte_ack  (TX_ACK),
        .out_byte  (TX_BYTE),
        .out_valid (TX_VALID),
        .out_eoi   (TX_EOI),
        .busy      (TERM_BUSY)
    );

    // Command buffer fill
    always @(posedge CLK_SYS) begin
        if (RX_VALID && !rx_exec && state == ST_IDLE && !wr_cnt[`TAC_BUF_AW]) begin
            cmd_buf[wr_cnt[`TAC_BUF_AW-1:0]] <= RX_BYTE;
        end
    end

    // Buffering, execute scan and settings
    always @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            wr_cnt         <= 8'h00;
            rd_idx         <= 8'h00;
            state          <= ST_IDLE;
            saved_term     <= `TAC_TERM_FACTORY;
            saved_auto     <= `TAC_AUTO_FACTORY;
            TERM_SEL       <= `TAC_TERM_FACTORY;
            AUTO_FILTER_ON <= `TAC_AUTO_FACTORY;
            pend_term      <= 2'h0;
            pend_auto      <= 1'b0;
            have_term      <= 1'b0;
            have_auto      <= 1'b0;
            bad            <= 1'b0;
            pend_letter    <= 8'h00;
            CMD_INVALID    <= 1'b0;
            BUF_OVERFLOW   <= 1'b0;
            PRIMARY_ADDR   <= `TAC_DEFAULT_ADDR;
        end else begin
            CMD_INVALID <= 1'b0;
            if (clear_req) begin
                TERM_SEL       <= saved_term;
                AUTO_FILTER_ON <= saved_auto;
                wr_cnt         <= 8'h00;
                state          <= ST_IDLE;
                BUF_OVERFLOW   <= 1'b0;
                if (SAVE_DEFAULTS_CMD) begin
                    saved_term     <= TERM_SEL;
                    saved_auto     <= AUTO_FILTER_ON;
                    TERM_SEL       <= TERM_SEL;
                    AUTO_FILTER_ON <= AUTO_FILTER_ON;
                end
            end else begin
                case (state)
                    ST_IDLE: begin
                        if (rx_exec) begin
                            state       <= ST_SCAN;
                            rd_idx      <= 8'h00;
                            have_term   <= 1'b0;
                            have_auto   <= 1'b0;
                            bad         <= BUF_OVERFLOW;
                            pend_letter <= 8'h00;
                        end else if (RX_VALID) begin
                            if (wr_cnt[`TAC_BUF_AW]) begin
                                BUF_OVERFLOW <= 1'b1;
                            end else begin
                                wr_cnt <= wr_cnt + 8'h01;
                            end
                        end
                    end
                    ST_SCAN: begin
                        if (rd_idx == wr_cnt) begin
                            state <= ST_DONE;
                        end else begin
                            rd_idx <= rd_idx + 8'h01;
                            if (pend_letter == `TAC_CHAR_TERM) begin
                                if (scan_byte >= `TAC_CHAR_ZERO &&
                                    scan_byte <= `TAC_CHAR_THREE) begin
                                    pend_term <= scan_byte[1:0];
                                    have_term <= 1'b1;
                                end else begin
                                    bad <= 1'b1;
                                end
                                pend_letter <= 8'h00;
                            end else if (pend_letter == `TAC_CHAR_AUTO) begin
                                if (scan_byte == `TAC_CHAR_ZERO ||
                                    scan_byte == `TAC_CHAR_ZERO + 8'h01) begin
                                    pend_auto <= scan_byte[0];
                                    have_auto <= 1'b1;
                                end else begin
                                    bad <= 1'b1;
                                end
                                pend_letter <= 8'h00;
                            end else begin
                                pend_letter <= scan_byte;
                            end
                        end
                    end
                    ST_DONE: begin
                        // A dangling letter without its digit is invalid too
                        if (bad || pend_letter == `TAC_CHAR_TERM ||
                            pend_letter == `TAC_CHAR_AUTO) begin
                            CMD_INVALID <= 1'b1;
                        end else begin
                            if (have_term) begin
                                TERM_SEL <= pend_term;
                            end
                            if (have_auto) begin
                                AUTO_FILTER_ON <= pend_auto;
                            end
                        end
                        wr_cnt       <= 8'h00;
                        BUF_OVERFLOW <= 1'b0;
                        state        <= ST_IDLE;
                    end
                    default: begin
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Rise time selection
    always @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            RISE_SEL      <= `TAC_RISE_NONE;
            FILTER_ACTIVE <= 1'b0;
        end else if (MAIN_FILTER_ON) begin
            RISE_SEL      <= PROG_RISE;
            FILTER_ACTIVE <= 1'b1;
        end else if (AUTO_FILTER_ON) begin
            FILTER_ACTIVE <= (GAIN_EXP == `TAC_GAIN_1E8) || (GAIN_EXP == `TAC_GAIN_1E9) ||
                             (GAIN_EXP == `TAC_GAIN_1E10);
            case (GAIN_EXP)
                `TAC_GAIN_1E8:  RISE_SEL <= `TAC_RISE_10US;
                `TAC_GAIN_1E9:  RISE_SEL <= `TAC_RISE_30US;
                `TAC_GAIN_1E10: RISE_SEL <= `TAC_RISE_100US;
                default:        RISE_SEL <= `TAC_RISE_NONE;
            endcase
        end else begin
            RISE_SEL      <= `TAC_RISE_NONE;
            FILTER_ACTIVE <= 1'b0;
        end
    end

    // Remote state and front panel gating
    always @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            REMOTE              <= 1'b0;
            HOST_CONTROL_LAMP   <= 1'b0;
            ren_seen            <= 1'b0;
            PANEL_KEY_OUT_VALID <= 1'b0;
            PANEL_KEY_OUT_CODE  <= 8'h00;
        end else begin
            ren_seen <= REN;
            if (!REN || GO_TO_LOCAL) begin
                REMOTE <= 1'b0;
            end else if (REMOTE && LOCAL_KEY && !LOCAL_LOCKOUT) begin
                REMOTE <= 1'b0;
            end else if (ren_seen && LISTEN_ADDRESSED) begin
                REMOTE <= 1'b1;
            end
            HOST_CONTROL_LAMP   <= REMOTE;
            PANEL_KEY_OUT_VALID <= PANEL_KEY_VALID && !REMOTE;
            PANEL_KEY_OUT_CODE  <= PANEL_KEY_CODE;
        end
    end

endmodule
`default_nettype wire

// file: inc/tac_consts.vh
// Constants for the terminator, auto-filter and remote control block
`ifndef TAC_CONSTS_VH
`define TAC_CONSTS_VH

`define TAC_CHAR_CR        8'h0D
`define TAC_CHAR_LF        8'h0A
`define TAC_CHAR_EXEC      8'h58
`define TAC_CHAR_TERM      8'h59
`define TAC_CHAR_AUTO      8'h5A
`define TAC_CHAR_ZERO      8'h30
`define TAC_CHAR_THREE     8'h33

`define TAC_TERM_CRLF      2'h0
`define TAC_TERM_LFCR      2'h1
`define TAC_TERM_CR        2'h2
`define TAC_TERM_LF        2'h3
`define TAC_TERM_FACTORY   2'h0
`define TAC_AUTO_FACTORY   1'b1

`define TAC_BUF_DEPTH      128
`define TAC_BUF_AW         7
`define TAC_DEFAULT_ADDR   5'h16

`define TAC_GAIN_W         4
`define TAC_GAIN_1E8       4'h8
`define TAC_GAIN_1E9       4'h9
`define TAC_GAIN_1E10      4'hA

`define TAC_RISE_W         3
`define TAC_RISE_NONE      3'h0
`define TAC_RISE_10US      3'h1
`define TAC_RISE_30US      3'h2
`define TAC_RISE_100US     3'h3

`endif

// file: hdl/tac_term_seq.v
// Output string terminator sequencer with end-or-identify on the last byte
`timescale 1ns/1ps
`default_nettype none
`include "tac_consts.vh"

module tac_term_seq (
    input  wire       clk,
    input  wire       rst_n,
    input  wire [1:0] term_sel,
    input  wire       eoi_en,
    input  wire       start,
    input  wire       byte_ack,
    output reg  [7:0] out_byte,
    output reg        out_valid,
    output reg        out_eoi,
    output wire       busy
);

    reg [1:0] step;
    reg [1:0] sel;

    assign busy = (step != 2'h0);

    // Byte count and order per selected terminator
    function [7:0] term_byte;
        input [1:0] s;
        input       second;
        begin
            case (s)
                `TAC_TERM_CRLF: term_byte = second ? `TAC_CHAR_LF : `TAC_CHAR_CR;
                `TAC_TERM_LFCR: term_byte = second ? `TAC_CHAR_CR : `TAC_CHAR_LF;
                `TAC_TERM_CR:   term_byte = `TAC_CHAR_CR;
                default:        term_byte = `TAC_CHAR_LF;
            endcase
        end
    endfunction

    wire two_bytes = (sel == `TAC_TERM_CRLF) || (sel == `TAC_TERM_LFCR);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            step      <= 2'h0;
            sel       <= `TAC_TERM_FACTORY;
            out_byte  <= 8'h00;
            out_valid <= 1'b0;
            out_eoi   <= 1'b0;
        end else begin
            case (step)
                2'h0: begin
                    if (start) begin
                        sel       <= term_sel;
                        step      <= 2'h1;
                        out_valid <= 1'b1;
                        out_byte  <= term_byte(term_sel, 1'b0);
                        out_eoi   <= eoi_en &&
                                     (term_sel == `TAC_TERM_CR ||
                                      term_sel == `TAC_TERM_LF);
                    end
                end
                2'h1: begin
                    if (byte_ack) begin
                        if (two_bytes) begin
                            step     <= 2'h2;
                            out_byte <= term_byte(sel, 1'b1);
                            out_eoi  <= eoi_en;
                        end else begin
                            step      <= 2'h0;
                            out_valid <= 1'b0;
                            out_eoi   <= 1'b0;
                        end
                    end
                end
                2'h2: begin
                    if (byte_ack) begin
                        step      <= 2'h0;
                        out_valid <= 1'b0;
                        out_eoi   <= 1'b0;
                    end
                end
                default: begin
                    step      <= 2'h0;
                    out_valid <= 1'b0;
                    out_eoi   <= 1'b0;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// file: tb/tac_props.sv
// Checker for terminator output, remote state, panel keys and rise selection
`timescale 1ns/1ps
`default_nettype none
module tac_props (
    input wire logic       CLK_SYS,
    input wire logic       RST_N,
    input wire logic       STRING_DONE,
    input wire logic       TALK_ADDRESSED,
    input wire logic       TERM_BUSY,
    input wire logic       TX_VALID,
    input wire logic [7:0] TX_BYTE,
    input wire logic       TX_ACK,
    input wire logic [1:0] TERM_SEL,
    input wire logic       REMOTE,
    input wire logic       HOST_CONTROL_LAMP,
    input wire logic       PANEL_KEY_VALID,
    input wire logic       PANEL_KEY_OUT_VALID,
    input wire logic       REN,
    input wire logic       LISTEN_ADDRESSED,
    input wire logic       LOCAL_KEY,
    input wire logic       LOCAL_LOCKOUT,
    input wire logic [4:0] PRIMARY_ADDR,
    input wire logic       MAIN_FILTER_ON,
    input wire logic       AUTO_FILTER_ON,
    input wire logic [2:0] PROG_RISE,
    input wire logic [3:0] GAIN_EXP,
    input wire logic [2:0] RISE_SEL
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    property p_term_first;
        STRING_DONE && TALK_ADDRESSED && !TERM_BUSY |=>
            TX_VALID && TX_BYTE == ($past(TERM_SEL[0]) ? 8'h0A : 8'h0D);
    endproperty
    a_term_first: assert property (p_term_first)
        else $error("First terminator byte wrong");
    property p_tx_hold;
        TX_VALID && !TX_ACK |=> TX_VALID && $stable(TX_BYTE);
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("Byte dropped before ack");
    property p_remote_entry;
        $rose(REMOTE) |-> $past(REN, 2) && $past(LISTEN_ADDRESSED);
    endproperty
    a_remote_entry: assert property (p_remote_entry) else $error("Remote without REN");
    property p_panel_lock;
        REMOTE && PANEL_KEY_VALID |=> !PANEL_KEY_OUT_VALID;
    endproperty
    a_panel_lock: assert property (p_panel_lock) else $error("Key passed in remote");
    property p_local_exit;
        REMOTE && LOCAL_KEY && !LOCAL_LOCKOUT |=> !REMOTE;
    endproperty
    a_local_exit: assert property (p_local_exit) else $error("Local key ignored");
    property p_lamp;
        REMOTE [*2] |-> HOST_CONTROL_LAMP;
    endproperty
    a_lamp: assert property (p_lamp) else $error("Lamp dark in remote");
    property p_addr;
        PRIMARY_ADDR == 5'h16;
    endproperty
    a_addr: assert property (p_addr) else $error("Primary address wrong");
    property p_rise_main;
        MAIN_FILTER_ON |=> RISE_SEL == $past(PROG_RISE);
    endproperty
    a_rise_main: assert property (p_rise_main) else $error("Programmed rise ignored");
    property p_rise_low;
        !MAIN_FILTER_ON && AUTO_FILTER_ON && GAIN_EXP < 4'h8 |=> RISE_SEL == 3'h0;
    endproperty
    a_rise_low: assert property (p_rise_low) else $error("Filter at low gain");
endmodule
bind tac_top tac_props u_props (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
    .STRING_DONE(STRING_DONE), .TALK_ADDRESSED(TALK_ADDRESSED), .TERM_BUSY(TERM_BUSY),
    .TX_VALID(TX_VALID), .TX_BYTE(TX_BYTE), .TX_ACK(TX_ACK), .TERM_SEL(TERM_SEL),
    .REMOTE(REMOTE), .HOST_CONTROL_LAMP(HOST_CONTROL_LAMP), .PANEL_KEY_VALID(PANEL_KEY_VALID),
    .PANEL_KEY_OUT_VALID(PANEL_KEY_OUT_VALID), .REN(REN), .LISTEN_ADDRESSED(LISTEN_ADDRESSED),
    .LOCAL_KEY(LOCAL_KEY), .LOCAL_LOCKOUT(LOCAL_LOCKOUT), .PRIMARY_ADDR(PRIMARY_ADDR),
    .MAIN_FILTER_ON(MAIN_FILTER_ON), .AUTO_FILTER_ON(AUTO_FILTER_ON),
    .PROG_RISE(PROG_RISE), .GAIN_EXP(GAIN_EXP), .RISE_SEL(RISE_SEL));
`default_nettype wire

// file: tb/tac_ctl_model.sv
// Bus controller model: command bytes, remote setup, output handshake
`timescale 1ns/1ps
`default_nettype none
module tac_ctl_model (
    input  wire logic       clk,
    input  wire logic       tx_valid,
    output var  logic [7:0] rx_byte,
    output var  logic       rx_valid,
    output var  logic       tx_ack,
    output var  logic       ren,
    output var  logic       listen
);
    initial begin
        rx_byte = 8'hFF;
        rx_valid = 1'b0;
        ren = 1'b0;
        listen = 1'b0;
    end
    // Random stalls on the output handshake
    always @(negedge clk) tx_ack <= tx_valid & $urandom_range(0, 1);
    task automatic send(input logic [7:0] b);
        @(negedge clk);
        rx_byte <= b;
        rx_valid <= 1'b1;
        @(negedge clk);
        rx_valid <= 1'b0;
        rx_byte <= ~b;
    endtask
    task automatic ren_on();
        ren <= 1'b1;
    endtask
    // Remote enable first, then listen addressing
    task automatic remote_on();
        ren <= 1'b1;
        repeat (3) @(negedge clk);
        listen <= 1'b1;
        repeat (2) @(negedge clk);
        listen <= 1'b0;
    endtask
endmodule
`default_nettype wire

// file: tb/tac_top_test.sv
// Self-checking bench for the command, terminator and remote block
`timescale 1ns/1ps
`default_nettype none
module tac_top_test;
    logic clk = 0, rst_n = 0, dcl = 0, sdc = 0, save = 0, eoi = 0, talk = 0, llo = 0;
    logic lkey = 0, kval = 0, sdone = 0, mfil = 0, gtl = 0;
    logic [7:0] kcode = 8'h00;
    logic [2:0] prise = 3'h0;
    logic [3:0] gain = 4'h3;
    wire [7:0] rx_byte, tx_byte, kout;
    wire rx_valid, tx_ack, ren, listen, tx_valid, tx_eoi, kout_v, inv, remote, lamp, afil;
    wire fact, ovf;
    wire [1:0] tsel;
    wire [2:0] rise;
    wire [4:0] addr;
    int error_cnt = 0;
    int n_compared = 0;
    logic [8:0] exp_q[$];
    int inv_cnt = 0, key_cnt = 0;
    always #4 clk = ~clk;
    tac_top uut (.CLK_SYS(clk), .RST_N(rst_n), .RX_BYTE(rx_byte), .RX_VALID(rx_valid),
        .DEV_CLEAR(dcl), .SEL_DEV_CLEAR(sdc), .SAVE_DEFAULTS_CMD(save), .EOI_ENABLE(eoi),
        .REN(ren), .LISTEN_ADDRESSED(listen), .TALK_ADDRESSED(talk), .LOCAL_LOCKOUT(llo),
        .GO_TO_LOCAL(gtl), .LOCAL_KEY(lkey), .PANEL_KEY_VALID(kval), .PANEL_KEY_CODE(kcode),
        .STRING_DONE(sdone), .TX_ACK(tx_ack), .MAIN_FILTER_ON(mfil), .PROG_RISE(prise),
        .GAIN_EXP(gain), .TX_BYTE(tx_byte), .TX_VALID(tx_valid), .TX_EOI(tx_eoi),
        .TERM_BUSY(), .TERM_SEL(tsel), .AUTO_FILTER_ON(afil), .RISE_SEL(rise),
        .FILTER_ACTIVE(fact), .REMOTE(remote), .HOST_CONTROL_LAMP(lamp),
        .PANEL_KEY_OUT_VALID(kout_v), .PANEL_KEY_OUT_CODE(kout), .CMD_INVALID(inv),
        .BUF_OVERFLOW(ovf), .PRIMARY_ADDR(addr));
    tac_ctl_model ctl (.clk(clk), .tx_valid(tx_valid), .rx_byte(rx_byte), .rx_valid(rx_valid),
        .tx_ack(tx_ack), .ren(ren), .listen(listen));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    always @(posedge clk) begin
        if (inv) inv_cnt <= inv_cnt + 1;
        if (kout_v) key_cnt <= key_cnt + 1;
        if (tx_valid && tx_ack) begin
            if (exp_q.size() == 0) chk(tx_byte, 8'hEE);
            else chk({tx_eoi, tx_byte}, exp_q.pop_front());
        end
    end
    task automatic cmd(input string s);
        for (int i = 0; i < s.len(); i++) ctl.send(s[i]);
        repeat (s.len() + 8) @(negedge clk);
    endtask
    task automatic pulse(ref logic sig);
        @(negedge clk);
        sig = 1'b1;
        @(negedge clk);
        sig = 1'b0;
        repeat (2) @(negedge clk);
    endtask
    task automatic term(input logic [1:0] k);
        eoi <= $urandom_range(0, 1);
        talk <= 1'b1;
        @(negedge clk);
        if (k < 2) exp_q.push_back({1'b0, k[0] ? 8'h0A : 8'h0D});
        exp_q.push_back({eoi, k[0] ? 8'h0D : 8'h0A});
        if (k > 1) exp_q[0][7:0] = k[0] ? 8'h0A : 8'h0D;
        pulse(sdone);
        for (int i = 0; i < 40 && exp_q.size() > 0; i++) @(negedge clk);
        chk(exp_q.size(), 0);
        chk(tx_valid, 1'b0);
    endtask
    task automatic give_verdict();
        if (error_cnt == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #400000;
        error_cnt++;
        give_verdict();
    end
    initial begin
        repeat (8) @(negedge clk);
        rst_n <= 1'b1;
        void'($urandom(83));
        @(negedge clk);
        chk({tsel, afil, addr}, {2'h0, 1'b1, 5'h16});
        for (int k = 0; k < 4; k++) begin
            cmd($sformatf("Y%0dX", k));
            chk(tsel, k);
            term(k);
        end
        cmd("Y4X");
        chk({inv_cnt[7:0], tsel}, {8'h01, 2'h3});
        cmd("Z0X");
        chk(afil, 1'b0);
        cmd("Z2X");
        chk({inv_cnt[7:0], afil}, {8'h02, 1'b0});
        ctl.send("Y");
        ctl.send("1");
        repeat (12) @(negedge clk);
        chk(tsel, 2'h3);
        cmd("X");
        chk(tsel, 2'h1);
        cmd("Y2Z0X");
        pulse(save);
        cmd("Y0Z1X");
        pulse(dcl);
        chk({tsel, afil}, {2'h2, 1'b0});
        cmd("Y1Z1X");
        pulse(sdc);
        chk({tsel, afil}, {2'h2, 1'b0});
        for (int i = 0; i < 129; i++) ctl.send("A");
        chk(ovf, 1'b1);
        cmd("X");
        repeat (130) @(negedge clk);
        chk({inv_cnt[7:0], ovf, tsel}, {8'h03, 1'b0, 2'h2});
        for (int a = 0; a < 2; a++) begin
            cmd(a ? "Z1X" : "Z0X");
            repeat (30) begin
                gain <= $urandom_range(3, 10);
                mfil <= $urandom_range(0, 1);
                prise <= $urandom_range(0, 7);
                repeat (3) @(negedge clk);
                chk(rise, mfil ? prise : (a && gain > 7) ? gain - 4'h7 : 3'h0);
                chk(fact, mfil | (a && gain > 7));
            end
        end
        ctl.ren_on();
        repeat (6) @(negedge clk);
        chk(remote, 1'b0);
        ctl.remote_on();
        chk({remote, lamp}, 2'b11);
        term(2'h2);
        kcode <= $urandom_range(0, 255);
        pulse(kval);
        chk(key_cnt, 0);
        llo <= 1'b1;
        pulse(lkey);
        chk(remote, 1'b1);
        llo <= 1'b0;
        pulse(lkey);
        chk({remote, lamp}, 2'b00);
        ctl.remote_on();
        chk(remote, 1'b1);
        pulse(gtl);
        chk({remote, lamp}, 2'b00);
        pulse(kval);
        chk({key_cnt[7:0], kout}, {8'h01, kcode});
        give_verdict();
    end
endmodule
`default_nettype wire
